//--- rtl/sbw_pkg.sv
`default_nettype none
package sbw_pkg;
  // register indices on the serial link
  localparam logic [6:0] ADDR_MODE = 7'h01; // chip mode request
  localparam logic [6:0] ADDR_HW = 7'h02; // hardware_supply_control
  localparam logic [6:0] ADDR_WDC = 7'h03; // watchdog_control
  localparam logic [6:0] ADDR_BUS1 = 7'h04; // transceiver_mode_control
  localparam logic [6:0] ADDR_BUS2 = 7'h05; // peak_threshold_control
  localparam logic [6:0] ADDR_EXT = 7'h07; // external_wake_control
  // writable bit masks, reserved bits stay zero
  localparam logic [7:0] MASK_HW = 8'hFB;
  localparam logic [7:0] MASK_WDC = 8'hF7;
  localparam logic [7:0] MASK_BUS1 = 8'h07;
  localparam logic [7:0] MASK_BUS2 = 8'h20;
  localparam logic [7:0] MASK_EXT = 8'hA7;
  // power-on / soft reset values
  localparam logic [7:0] RST_HW = 8'h00;
  localparam logic [7:0] RST_WDC = 8'h14;
  localparam logic [7:0] RST_BUS1 = 8'h00;
  localparam logic [7:0] RST_BUS2 = 8'h00;
  localparam logic [7:0] RST_EXT = 8'h07;
  // soft reset keeps voltage select and load share
  localparam logic [7:0] KEEP_HW_SOFT = 8'h88;
  // restart: keep checksum, type, bus-wake start; period code 100
  localparam logic [7:0] KEEP_WDC_RESTART = 8'hB0;
  localparam logic [7:0] SET_WDC_RESTART = 8'h04;
  // fail-safe wake source values
  localparam logic [7:0] KEEP_BUS1_FS = 8'h04;
  localparam logic [7:0] SET_BUS1_FS = 8'h01;
  localparam logic [7:0] KEEP_EXT_FS = 8'hA0;
  localparam logic [7:0] SET_EXT_FS = 8'h07;
  // field positions
  localparam int HW_FO_EN = 5; // failure_out_sw_enable
  localparam int HW_VSEL = 7; // aux_reg_voltage_select
  localparam int HW_LS = 3; // aux_reg_load_share
  localparam int WDC_STOP_DIS = 6; // wdog_stop_disable_lo
  localparam int WDC_WIN = 5; // wdog_window_select
  localparam int WDC_BUS_WAKE = 4; // wdog_start_on_bus_wake
  localparam int BUS1_SWK = 2; // selective_wake
  localparam int BUS2_PEAK = 5; // peak_current_threshold
  localparam int EXT_INT_GLOBAL = 7;
  // transceiver low mode bits
  localparam logic [1:0] CAN_OFF = 2'h0;
  localparam logic [1:0] CAN_WAKE = 2'h1;
  localparam logic [1:0] CAN_RXO = 2'h2;
  localparam logic [1:0] CAN_NORM = 2'h3;
  // chip mode field codes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SLEEP = 2'h1;
  localparam logic [1:0] MODE_STOP = 2'h2;
  localparam logic [1:0] MODE_SOFTRST = 2'h3;
  // serial frame and address byte lengths in bits
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] ADDR_BITS = 5'h08;
  // watchdog period in ms for each period code
  localparam logic [9:0] WD_MS_C0 = 10'h00A;
  localparam logic [9:0] WD_MS_C1 = 10'h014;
  localparam logic [9:0] WD_MS_C2 = 10'h032;
  localparam logic [9:0] WD_MS_C3 = 10'h064;
  localparam logic [9:0] WD_MS_C4 = 10'h0C8;
  localparam logic [9:0] WD_MS_C5 = 10'h1F4;
  localparam logic [9:0] WD_MS_C6 = 10'h3E8;
  localparam logic [9:0] WD_MS_RSVD = 10'h000;

  typedef enum logic [5:0] {
    ST_INIT = 6'b00_0001,
    ST_NORMAL = 6'b00_0010,
    ST_SLEEP = 6'b00_0100,
    ST_STOP = 6'b00_1000,
    ST_RESTART = 6'b01_0000,
    ST_FAILSAFE = 6'b10_0000
  } sbw_state_t;

  typedef struct packed {
    logic [7:0] hw;
    logic [7:0] wdc;
    logic [7:0] bus1;
    logic [7:0] bus2;
    logic [7:0] ext;
  } sbw_regs_t;
endpackage : sbw_pkg
`default_nettype wire

//--- rtl/sbw_ctrl_regs.sv
`default_nettype none
module sbw_ctrl_regs (
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  input wire logic CSN_I, // serial select, active low
  input wire logic SCLK_I,
  input wire logic SDI_I,
  input wire logic SYSTEM_ERROR_FLAG_I, // system_error_flag
  input wire logic FAILURE_FLAG_I, // detected failure, cleared by software elsewhere
  input wire logic RESTART_REQ_I,
  input wire logic FAILSAFE_REQ_I,
  input wire logic WAKE_I,
  input wire logic STATUS_EVT_I,
  output logic SDO_O,
  output logic SPI_FAIL_O,
  output logic FAIL_OUT_O,
  output logic INT_O,
  output logic [5:0] CHIP_STATE_O,
  output logic [2:0] CAN_MODE_O,
  output logic WD_STOP_DISABLE_O,
  output logic WD_WINDOW_O,
  output logic WD_BUS_WAKE_START_O,
  output logic [9:0] WD_PERIOD_MS_O,
  output logic PEAK_HIGH_O,
  output logic AUX_VSEL_O,
  output logic AUX_LS_O
);
  // serial shifter state
  logic sclk_q, sclk_d;
  logic csn_q, csn_d;
  logic [4:0] cnt_q, cnt_d;
  logic [15:0] sh_q, sh_d;
  logic [7:0] so_q, so_d;
  // register file and chip mode
  sbw_pkg::sbw_regs_t regs_q, regs_d;
  sbw_pkg::sbw_state_t st_q, st_d;
  // registered outputs
  logic fail_q, fail_d;
  logic int_q, int_d;
  logic spif_q, spif_d;
  logic [9:0] per_q, per_d;
  // decoded frame
  logic frame_end, commit, wr;
  logic [6:0] waddr;
  logic [7:0] wdata;
  logic soft_rst, go_sleep, go_stop, go_restart;

  // chip mode field as seen on a read
  function automatic logic [1:0] mode_code(input sbw_pkg::sbw_state_t s);
    case (s)
      sbw_pkg::ST_SLEEP: mode_code = sbw_pkg::MODE_SLEEP;
      sbw_pkg::ST_STOP: mode_code = sbw_pkg::MODE_STOP;
      default: mode_code = sbw_pkg::MODE_NORMAL;
    endcase
  endfunction

  // read mux, used by the shifter while select is high and after the address byte
  function automatic logic [7:0] rd_reg(input sbw_pkg::sbw_regs_t r, input sbw_pkg::sbw_state_t s,
                                        input logic [6:0] a);
    if (a == sbw_pkg::ADDR_MODE) begin
      rd_reg = {mode_code(s), 6'h00};
    end else if (a == sbw_pkg::ADDR_HW) begin
      rd_reg = r.hw;
    end else if (a == sbw_pkg::ADDR_WDC) begin
      rd_reg = r.wdc;
    end else if (a == sbw_pkg::ADDR_BUS1) begin
      rd_reg = r.bus1;
    end else if (a == sbw_pkg::ADDR_BUS2) begin
      rd_reg = r.bus2;
    end else if (a == sbw_pkg::ADDR_EXT) begin
      rd_reg = r.ext;
    end else begin
      rd_reg = 8'h00; // unmapped reads as zero
    end
  endfunction

  // watchdog period lookup in ms
  // reserved code gives zero, so a bad setting never looks like a valid period
  function automatic logic [9:0] wd_ms(input logic [2:0] c);
    case (c)
      3'h0: wd_ms = sbw_pkg::WD_MS_C0;
      3'h1: wd_ms = sbw_pkg::WD_MS_C1;
      3'h2: wd_ms = sbw_pkg::WD_MS_C2;
      3'h3: wd_ms = sbw_pkg::WD_MS_C3;
      3'h4: wd_ms = sbw_pkg::WD_MS_C4;
      3'h5: wd_ms = sbw_pkg::WD_MS_C5;
      3'h6: wd_ms = sbw_pkg::WD_MS_C6;
      default: wd_ms = sbw_pkg::WD_MS_RSVD; // reserved code
    endcase
  endfunction

  // frame decode: bit 15 write, 14:8 address, 7:0 data
  assign frame_end = CSN_I & ~csn_q;
  assign commit = frame_end & (cnt_q == sbw_pkg::FRAME_BITS);
  assign wr = commit & sh_q[15];
  assign waddr = sh_q[14:8];
  assign wdata = sh_q[7:0];

  // serial shifter next state, msb first, sampled on sclk rise
  always_comb begin
    sclk_d = SCLK_I;
    csn_d = CSN_I;
    cnt_d = cnt_q;
    sh_d = sh_q;
    so_d = so_q;
    if (CSN_I) begin
      cnt_d = 5'h00;
      so_d = rd_reg(regs_q, st_q, sbw_pkg::ADDR_MODE); // first byte shows mode
    end else if (SCLK_I & ~sclk_q) begin
      sh_d = {sh_q[14:0], SDI_I};
      if (cnt_q != 5'h1F) begin
        cnt_d = cnt_q + 5'h01; // saturate so long frames stay invalid
      end
      if (cnt_q + 5'h01 == sbw_pkg::ADDR_BITS) begin
        // previous contents, before this frame's write lands
        so_d = rd_reg(regs_q, st_q, {sh_q[5:0], SDI_I});
      end else begin
        so_d = {so_q[6:0], 1'b0};
      end
    end
  end

  // serial shifter registers
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      sclk_q <= 1'b0;
      csn_q <= 1'b1;
      cnt_q <= 5'h00;
      sh_q <= 16'h0000;
      so_q <= 8'h00;
    end else begin
      sclk_q <= sclk_d;
      csn_q <= csn_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      so_q <= so_d;
    end
  end

  // mode requests from a committed write
  assign soft_rst = wr & (waddr == sbw_pkg::ADDR_MODE) & (wdata[7:6] == sbw_pkg::MODE_SOFTRST);
  assign go_sleep = wr & (waddr == sbw_pkg::ADDR_MODE) & (wdata[7:6] == sbw_pkg::MODE_SLEEP)
                    & (st_q != sbw_pkg::ST_STOP); // stop cannot go straight to sleep
  assign go_stop = wr & (waddr == sbw_pkg::ADDR_MODE) & (wdata[7:6] == sbw_pkg::MODE_STOP);
  // a wake in sleep or fail-safe passes through restart first unless a soft reset or fail-safe request comes in the same cycle
  assign go_restart = (st_q != sbw_pkg::ST_RESTART) & ~soft_rst & ~FAILSAFE_REQ_I
                      & (RESTART_REQ_I | (WAKE_I & (st_q == sbw_pkg::ST_SLEEP || st_q == sbw_pkg::ST_FAILSAFE)));

  // chip mode and register file next values
  always_comb begin
    st_d = st_q;
    regs_d = regs_q;
    spif_d = 1'b0;
    if (wr && waddr == sbw_pkg::ADDR_HW) begin
      regs_d.hw = wdata & sbw_pkg::MASK_HW;
    end else if (wr && waddr == sbw_pkg::ADDR_WDC) begin
      if (^wdata) begin
        spif_d = 1'b1; // odd parity rejected
      end else begin
        regs_d.wdc = wdata & sbw_pkg::MASK_WDC;
      end
    end else if (wr && waddr == sbw_pkg::ADDR_BUS1) begin
      regs_d.bus1 = wdata & sbw_pkg::MASK_BUS1; // only path to bit 2 besides soft reset clearing it
    end else if (wr && waddr == sbw_pkg::ADDR_BUS2) begin
      if (st_q == sbw_pkg::ST_INIT || st_q == sbw_pkg::ST_NORMAL) begin
        regs_d.bus2 = wdata & sbw_pkg::MASK_BUS2;
      end
      // other modes: dropped, no fail flag, no interrupt
    end else if (wr && waddr == sbw_pkg::ADDR_EXT) begin
      regs_d.ext = wdata & sbw_pkg::MASK_EXT;
    end
    if (commit == 1'b0 && frame_end && cnt_q != 5'h00) begin
      spif_d = 1'b1; // wrong frame length
    end
    // mode changes, highest priority last
    if (wr && waddr == sbw_pkg::ADDR_MODE && wdata[7:6] == sbw_pkg::MODE_NORMAL
        && (st_q == sbw_pkg::ST_INIT || st_q == sbw_pkg::ST_NORMAL)) begin
      st_d = sbw_pkg::ST_NORMAL;
    end
    if (go_stop && (st_q == sbw_pkg::ST_INIT || st_q == sbw_pkg::ST_NORMAL)) begin
      st_d = sbw_pkg::ST_STOP; // normal, receive only, wake, off all kept
    end
    if (go_sleep) begin
      st_d = sbw_pkg::ST_SLEEP;
      if (!SYSTEM_ERROR_FLAG_I && regs_q.bus1[1]) begin
        // normal or receive only become wake capable
        regs_d.bus1 = {regs_q.bus1[7:2], sbw_pkg::CAN_WAKE};
      end
    end
    if (WAKE_I && st_q == sbw_pkg::ST_STOP) begin
      st_d = sbw_pkg::ST_NORMAL;
    end
    if (st_q == sbw_pkg::ST_RESTART) begin
      st_d = sbw_pkg::ST_NORMAL; // restart lasts one cycle here
    end
    if (go_restart) begin
      st_d = sbw_pkg::ST_RESTART;
      regs_d.hw[sbw_pkg::HW_FO_EN] = 1'b0;
      regs_d.wdc = (regs_q.wdc & sbw_pkg::KEEP_WDC_RESTART) | sbw_pkg::SET_WDC_RESTART;
    end
    if (FAILSAFE_REQ_I && !soft_rst && st_q != sbw_pkg::ST_FAILSAFE) begin
      // bus register value taken as 0000 0x01, bit 2 kept
      st_d = sbw_pkg::ST_FAILSAFE;
      regs_d.bus1 = (regs_q.bus1 & sbw_pkg::KEEP_BUS1_FS) | sbw_pkg::SET_BUS1_FS;
      regs_d.ext = (regs_q.ext & sbw_pkg::KEEP_EXT_FS) | sbw_pkg::SET_EXT_FS;
    end
    if (soft_rst) begin
      st_d = sbw_pkg::ST_INIT;
      regs_d.hw = (regs_q.hw & sbw_pkg::KEEP_HW_SOFT) | sbw_pkg::RST_HW;
      regs_d.wdc = sbw_pkg::RST_WDC;
      regs_d.bus1 = sbw_pkg::RST_BUS1;
      regs_d.bus2 = sbw_pkg::RST_BUS2;
      regs_d.ext = sbw_pkg::RST_EXT;
    end
  end

  // chip mode and register file registers; reset is power-on
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      st_q <= sbw_pkg::ST_INIT;
      regs_q <= {sbw_pkg::RST_HW, sbw_pkg::RST_WDC, sbw_pkg::RST_BUS1, sbw_pkg::RST_BUS2,
                 sbw_pkg::RST_EXT};
      spif_q <= 1'b0;
    end else begin
      st_q <= st_d;
      regs_q <= regs_d;
      spif_q <= spif_d;
    end
  end

  // output stage next values
  always_comb begin
    fail_d = regs_q.hw[sbw_pkg::HW_FO_EN] | FAILURE_FLAG_I;
    int_d = WAKE_I | (regs_q.ext[sbw_pkg::EXT_INT_GLOBAL] & STATUS_EVT_I);
    per_d = wd_ms(regs_q.wdc[2:0]);
  end

  // output stage registers
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      fail_q <= 1'b0;
      int_q <= 1'b0;
      per_q <= sbw_pkg::WD_MS_RSVD;
    end else begin
      fail_q <= fail_d;
      int_q <= int_d;
      per_q <= per_d;
    end
  end

  // every output straight from a flop
  assign SDO_O = so_q[7];
  assign SPI_FAIL_O = spif_q;
  assign FAIL_OUT_O = fail_q;
  assign INT_O = int_q;
  assign CHIP_STATE_O = st_q;
  assign CAN_MODE_O = regs_q.bus1[2:0];
  assign WD_STOP_DISABLE_O = regs_q.wdc[sbw_pkg::WDC_STOP_DIS];
  assign WD_WINDOW_O = regs_q.wdc[sbw_pkg::WDC_WIN];
  assign WD_BUS_WAKE_START_O = regs_q.wdc[sbw_pkg::WDC_BUS_WAKE];
  assign WD_PERIOD_MS_O = per_q;
  assign PEAK_HIGH_O = regs_q.bus2[sbw_pkg::BUS2_PEAK];
  assign AUX_VSEL_O = regs_q.hw[sbw_pkg::HW_VSEL];
  assign AUX_LS_O = regs_q.hw[sbw_pkg::HW_LS];

  // checks
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);

  AST_FO_HELD: assert property (FAILURE_FLAG_I |=> FAIL_OUT_O)
    else $error("failure outputs dropped while failure flag set");
  AST_RESTART_FO: assert property (go_restart |=> ##1 !FAIL_OUT_O || $past(FAILURE_FLAG_I))
    else $error("failure outputs still on after restart");
  AST_SOFT_KEEP: assert property (soft_rst |=> regs_q.hw == ($past(regs_q.hw) & sbw_pkg::KEEP_HW_SOFT))
    else $error("soft reset lost supply bits");
  AST_PARITY: assert property (wr && waddr == sbw_pkg::ADDR_WDC && ^wdata && !go_restart && !soft_rst
                               |=> $stable(regs_q.wdc) && SPI_FAIL_O)
    else $error("odd parity watchdog write accepted");
  AST_PERIOD: assert property (regs_q.wdc[2:0] == 3'h6 |=> WD_PERIOD_MS_O == 10'd1000)
    else $error("watchdog period lookup wrong");
  AST_RESTART_WDC: assert property (go_restart |=> regs_q.wdc[6] == 1'b0 && regs_q.wdc[2:0] == 3'h4
                                    && regs_q.wdc[5:4] == $past(regs_q.wdc[5:4]))
    else $error("restart watchdog value wrong");
  AST_SWK_KEEP: assert property (!(wr && waddr == sbw_pkg::ADDR_BUS1) && !soft_rst
                                 |=> $stable(regs_q.bus1[2]))
    else $error("selective wake bit changed by device");
  AST_SLEEP_CAN: assert property (go_sleep && !SYSTEM_ERROR_FLAG_I && regs_q.bus1[1] && !FAILSAFE_REQ_I && !go_restart
                                  |=> regs_q.bus1[1:0] == sbw_pkg::CAN_WAKE && st_q == sbw_pkg::ST_SLEEP)
    else $error("sleep entry left transceiver active");
  AST_STOP_RXO: assert property (go_stop && st_q == sbw_pkg::ST_NORMAL && regs_q.bus1[1:0] == sbw_pkg::CAN_RXO
                                 && !FAILSAFE_REQ_I && !go_restart |=> regs_q.bus1[1:0] == sbw_pkg::CAN_RXO)
    else $error("stop entry altered receive only");
  // low-power entries leave the transceiver field alone in these cases
  AST_SLEEP_KEEP: assert property (go_sleep && (SYSTEM_ERROR_FLAG_I || !regs_q.bus1[1]) && !go_restart
                                   && !FAILSAFE_REQ_I |=> $stable(regs_q.bus1))
    else $error("sleep entry changed a kept transceiver mode");
  AST_STOP_KEEP: assert property (go_stop && (st_q == sbw_pkg::ST_INIT || st_q == sbw_pkg::ST_NORMAL)
                                  && !FAILSAFE_REQ_I && !go_restart |=> $stable(regs_q.bus1))
    else $error("stop entry changed the transceiver mode");
  AST_FS_WAKE: assert property (FAILSAFE_REQ_I && !soft_rst && st_q != sbw_pkg::ST_FAILSAFE
                                |=> regs_q.bus1[1:0] == sbw_pkg::CAN_WAKE && regs_q.ext[2:0] == 3'h7)
    else $error("fail-safe wake sources not forced");
  // a wake or status event in the same cycle may still raise the interrupt on its own
  AST_PEAK_STOP: assert property (st_q == sbw_pkg::ST_STOP && wr && waddr == sbw_pkg::ADDR_BUS2
                                  |=> $stable(regs_q.bus2) && !SPI_FAIL_O
                                  && (!INT_O || $past(WAKE_I || STATUS_EVT_I)))
    else $error("peak threshold write took effect in stop");
  AST_RSVD: assert property ((regs_q.wdc & ~sbw_pkg::MASK_WDC) == 8'h00
                             && (regs_q.bus1 & ~sbw_pkg::MASK_BUS1) == 8'h00
                             && (regs_q.bus2 & ~sbw_pkg::MASK_BUS2) == 8'h00)
    else $error("reserved bit set");
  AST_INT_GLOBAL: assert property (!regs_q.ext[sbw_pkg::EXT_INT_GLOBAL] && !WAKE_I |=> !INT_O)
    else $error("interrupt raised by non-wake event");

  COV_SLEEP: cover property (go_sleep && regs_q.bus1[1:0] == sbw_pkg::CAN_NORM);
  COV_RESTART: cover property (go_restart && regs_q.hw[sbw_pkg::HW_FO_EN]);
  COV_PARITY_BAD: cover property (wr && waddr == sbw_pkg::ADDR_WDC && ^wdata);
  COV_FAILSAFE: cover property (st_q == sbw_pkg::ST_FAILSAFE);
  COV_STOP_RXO: cover property (go_stop && regs_q.bus1[1:0] == sbw_pkg::CAN_RXO);
endmodule // sbw_ctrl_regs
`default_nettype wire

//--- tb/sbw_host_model.sv
`default_nettype none
// host side of the serial link, one frame per call
module sbw_host_model (
  input wire logic clk_i,
  output logic csn_o, // select, active low
  output logic sclk_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    csn_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end

  // msb first; read byte taken from rises 9..16
  // each phase lasts one clock so the design sees every edge
  task automatic xfer(input int nbits, input logic [15:0] frm, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk_i);
    csn_o <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      @(posedge clk_i);
      if (i >= 8) begin
        rd = {rd[6:0], sdo_i};
      end
      sclk_o <= 1'b1;
      sdi_o <= frm[15-i];
      @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    @(posedge clk_i);
    csn_o <= 1'b1;
    // released data line must not keep its last level
    sdi_o <= ~sdi_o;
    repeat (5) @(posedge clk_i);
  endtask
endmodule // sbw_host_model
`default_nettype wire

//--- tb/sbw_ctrl_regs_tb.sv
`default_nettype none
`define SBW_CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module sbw_ctrl_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic system_error_flag = 1'b0;
  logic fail_flag = 1'b0;
  logic[3:0] req = 4'h0; // wake, failsafe, status, restart
  wire csn, sclk, sdi, sdo, spi_fail, fail_out, int_out;
  wire [5:0] state;
  wire [2:0] can_mode;
  wire wd_sd, wdog_window_select, wd_bw, peak, vsel, ls;
  wire [9:0] per;
  int n_mismatch = 0;
  int checks = 0;
  int nfail = 0; // spi failure pulses seen
  int nint = 0; // interrupt cycles seen
  logic [9:0] per_ms [8] = '{10'h00A, 10'h014, 10'h032, 10'h064, 10'h0C8, 10'h1F4, 10'h3E8, 10'h000};
  // {start value, error flag, stop entry, expected}
  logic [15:0] tbl [7] = '{16'h7005, 16'h3103, 16'h2001, 16'h6016, 16'h3013, 16'h1001, 16'h4014};
  logic [7:0] r;

  always #5 clk_sys = ~clk_sys;
  // one-cycle outputs are counted here, never missed
  always @(posedge clk_sys) begin
    if (spi_fail === 1'b1) nfail++;
    if (int_out === 1'b1) nint++;
  end

  sbw_host_model host (.clk_i(clk_sys), .csn_o(csn), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo));

  sbw_ctrl_regs dut (.CLK_SYS_I(clk_sys), .RESETN_I(resetn), .CSN_I(csn), .SCLK_I(sclk), .SDI_I(sdi),
    .SYSTEM_ERROR_FLAG_I(system_error_flag), .FAILURE_FLAG_I(fail_flag), .RESTART_REQ_I(req[3]), .FAILSAFE_REQ_I(req[1]),
    .WAKE_I(req[0]), .STATUS_EVT_I(req[2]), .SDO_O(sdo), .SPI_FAIL_O(spi_fail), .FAIL_OUT_O(fail_out),
    .INT_O(int_out), .CHIP_STATE_O(state), .CAN_MODE_O(can_mode), .WD_STOP_DISABLE_O(wd_sd),
    .WD_WINDOW_O(wdog_window_select), .WD_BUS_WAKE_START_O(wd_bw), .WD_PERIOD_MS_O(per), .PEAK_HIGH_O(peak),
    .AUX_VSEL_O(vsel), .AUX_LS_O(ls));

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    host.xfer(16, {1'b1, a, d}, x);
  endtask

  task automatic rd(input logic [6:0] a);
    host.xfer(16, {1'b0, a, 8'h00}, r);
  endtask

  // one-cycle request on an event input
  task automatic pulse(input int k);
    @(posedge clk_sys);
    req[k] <= 1'b1;
    @(posedge clk_sys);
    req[k] <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_mismatch++;
    end_sim();
  end

  initial begin
    int f;
    int n;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    // reset values
    rd(sbw_pkg::ADDR_WDC); `SBW_CHK(r, 8'h14)
    rd(sbw_pkg::ADDR_BUS1); `SBW_CHK(r, 8'h00)
    `SBW_CHK(per, 10'h0C8)
    `SBW_CHK(wd_bw, 1'b1)
    wr(7'h7F, 8'hFF);
    rd(7'h7F); `SBW_CHK(r, 8'h00)
    $display("reset test done");
    // every period code with even parity
    for (int c = 0; c < 8; c++) begin
      wr(sbw_pkg::ADDR_WDC, {^c[2:0], 4'h0, c[2:0]});
      `SBW_CHK(per, per_ms[c])
    end
    wr(sbw_pkg::ADDR_WDC, 8'h60);
    `SBW_CHK({wd_sd, wdog_window_select, wd_bw}, 3'h6)
    wr(sbw_pkg::ADDR_WDC, 8'h0F);
    rd(sbw_pkg::ADDR_WDC); `SBW_CHK(r, 8'h07)
    f = nfail;
    wr(sbw_pkg::ADDR_WDC, 8'h01);
    `SBW_CHK(nfail, f + 1)
    rd(sbw_pkg::ADDR_WDC); `SBW_CHK(r, 8'h07)
    host.xfer(15, 16'h8300, r);
    `SBW_CHK(nfail, f + 2)
    $display("watchdog test done");
    // all transceiver codes, reserved bits written high
    for (int m = 0; m < 8; m++) begin
      wr(sbw_pkg::ADDR_BUS1, {5'h1F, m[2:0]});
      rd(sbw_pkg::ADDR_BUS1); `SBW_CHK(r, {5'h00, m[2:0]})
      `SBW_CHK(can_mode, m[2:0])
    end
    wr(sbw_pkg::ADDR_MODE, 8'h00);
    `SBW_CHK(state, 6'h02)
    // enable cleared while a failure holds the outputs
    wr(sbw_pkg::ADDR_HW, 8'h20);
    `SBW_CHK(fail_out, 1'b1)
    fail_flag <= 1'b1;
    wr(sbw_pkg::ADDR_HW, 8'h00);
    `SBW_CHK(fail_out, 1'b1)
    fail_flag <= 1'b0;
    repeat (3) @(posedge clk_sys);
    `SBW_CHK(fail_out, 1'b0)
    // restart clears enable and rewrites watchdog fields
    wr(sbw_pkg::ADDR_HW, 8'h20);
    wr(sbw_pkg::ADDR_WDC, 8'h71);
    pulse(3);
    `SBW_CHK(fail_out, 1'b0)
    rd(sbw_pkg::ADDR_WDC); `SBW_CHK(r, 8'h34)
    rd(sbw_pkg::ADDR_HW); `SBW_CHK(r, 8'h00)
    `SBW_CHK(state, 6'h02)
    // soft reset keeps only voltage select and load share
    wr(sbw_pkg::ADDR_HW, 8'hA8);
    wr(sbw_pkg::ADDR_MODE, 8'hC0);
    rd(sbw_pkg::ADDR_HW); `SBW_CHK(r, 8'h88)
    `SBW_CHK({vsel, ls}, 2'h3)
    rd(sbw_pkg::ADDR_WDC); `SBW_CHK(r, 8'h14)
    `SBW_CHK(state, 6'h01)
    wr(sbw_pkg::ADDR_MODE, 8'h00);
    $display("restart test done");
    // low-power entries, host picks receive only, normal or off before stop
    for (int t = 0; t < 7; t++) begin
      wr(sbw_pkg::ADDR_BUS1, {4'h0, tbl[t][15:12]});
      system_error_flag <= tbl[t][8];
      wr(sbw_pkg::ADDR_MODE, tbl[t][4] ? 8'h80 : 8'h40);
      rd(sbw_pkg::ADDR_BUS1); `SBW_CHK(r, {4'h0, tbl[t][3:0]})
      `SBW_CHK(can_mode, tbl[t][2:0])
      system_error_flag <= 1'b0;
      pulse(0);
      `SBW_CHK(state, 6'h02)
    end
    $display("transceiver test done");
    // threshold write refused silently in stop
    wr(sbw_pkg::ADDR_BUS2, 8'hFF);
    rd(sbw_pkg::ADDR_BUS2); `SBW_CHK(r, 8'h20)
    wr(sbw_pkg::ADDR_EXT, 8'h80);
    wr(sbw_pkg::ADDR_MODE, 8'h80);
    rd(sbw_pkg::ADDR_MODE); `SBW_CHK(r, 8'h80)
    f = nfail;
    n = nint;
    wr(sbw_pkg::ADDR_BUS2, 8'h00);
    `SBW_CHK(peak, 1'b1)
    `SBW_CHK(nfail, f)
    `SBW_CHK(nint, n)
    pulse(2);
    `SBW_CHK(nint, n + 1)
    pulse(0);
    `SBW_CHK(state, 6'h02)
    wr(sbw_pkg::ADDR_EXT, 8'h00);
    n = nint;
    pulse(2);
    `SBW_CHK(nint, n)
    $display("threshold test done");
    // fail-safe forces wake sources, selective wake kept
    wr(sbw_pkg::ADDR_BUS1, 8'h07);
    wr(sbw_pkg::ADDR_EXT, 8'h80);
    pulse(1);
    `SBW_CHK(state, 6'h20)
    rd(sbw_pkg::ADDR_BUS1); `SBW_CHK(r, 8'h05)
    rd(sbw_pkg::ADDR_EXT); `SBW_CHK(r, 8'h87)
    $display("failsafe test done");
    end_sim();
  end
endmodule // sbw_ctrl_regs_tb
`default_nettype wire
